//--- pkg/fram_defs.svh
// constants for the two-wire byte memory slave: widths, field positions, reset values
// Function
// - memory holds 2K locations of eight bits
// - address is 8-bit row plus 3-bit segment
// - sda rising while scl high stops, aborts
// - sda falling while scl high starts anew
// - receiver pulls sda low in ninth clock
// - missing acknowledge ends the current operation
// - first byte: type, page select, direction
// - direction one reads, zero writes
// - write: second byte forms 11-bit address
// - read: latch page, keep low address bits
// - address increments after each data byte
// - address wraps from last to zero
// - read: eight bits out, ack continues
// - all bytes shifted most significant first
// - writes finish at bus speed, no polling
// - power-on reset returns interface to idle
// - master makes clock, device only slave
// - sample on scl rise, change on fall
// - write protect: no ack, store, increment
// - array write only after eighth data bit
`ifndef FRAM_DEFS_SVH
`define FRAM_DEFS_SVH

`define FRAM_DATA_W    8
`define FRAM_ROW_W     8
`define FRAM_SEG_W     3
`define FRAM_ADDR_W    11
`define FRAM_TYPE_MSB  7
`define FRAM_TYPE_LSB  4
`define FRAM_PAGE_MSB  3
`define FRAM_PAGE_LSB  1
`define FRAM_DIR_BIT   0
`define FRAM_LAST_BIT  3'h7
`define FRAM_CNT_RST   3'h0
`define FRAM_OE_B_RST  1'b1
`define FRAM_SDA_O_RST 1'b0
`define FRAM_ADDR_RST  11'h000
`define FRAM_BYTE_RST  8'h00

`endif

//--- pkg/fram_pkg.sv
// types shared by the serial slave engine and its byte store
`include "fram_defs.svh"
package fram_pkg;

    // engine states, one-hot
    typedef enum logic [9:0] {
        ST_IDLE  = 10'h001,
        ST_ADDR  = 10'h002,
        ST_AACK  = 10'h004,
        ST_WORD  = 10'h008,
        ST_WACK  = 10'h010,
        ST_WDATA = 10'h020,
        ST_DACK  = 10'h040,
        ST_RDATA = 10'h080,
        ST_RACK  = 10'h100,
        ST_RNEXT = 10'h200
    } link_state_t;

    // one memory access handed across the clock boundary
    typedef struct packed {
        logic                       we;
        logic [`FRAM_ADDR_W-1:0]    addr;
        logic [`FRAM_DATA_W-1:0]    data;
    } mem_req_t;

endpackage : fram_pkg

//--- core/fram_store.sv
// flip-flop byte array with registered read port
`timescale 1ns/10ps
`include "fram_defs.svh"
module fram_store
    import fram_pkg::*;
#(
    parameter int AW = `FRAM_ADDR_W,
    parameter int DW = `FRAM_DATA_W
)(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    // access port
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    // nonvolatile content, so the array itself carries no reset
    logic [DW-1:0] mem [0:(1<<AW)-1];

    ////////////////////////////////////////////////////////////////////////
    // array write, one cycle, far inside one bus clock
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[addr] <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (ce && rd_en) begin
            rdata <= mem[addr];
        end
    end

endmodule : fram_store

//--- core/i2c_fram_slave.sv
// two-wire serial slave front end for a 2K x 8 byte memory
`timescale 1ns/10ps
`include "fram_defs.svh"
module i2c_fram_slave
    import fram_pkg::*;
#(
    // device type code compared with the top nibble; value is arbitrary
    parameter logic [3:0] DEV_TYPE = 4'h5
)(
    // system clock domain
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // link clock domain, oversamples the bus
    input  wire logic link_clk,
    // bus pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_b,
    input  wire logic wp_i,
    // status
    output logic      xfer_busy
);

    localparam int AW = `FRAM_ADDR_W;
    localparam int DW = `FRAM_DATA_W;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [2:0]     scl_sync_r;
    logic [2:0]     sda_sync_r;
    logic [1:0]     wp_sync_r;
    logic [1:0]     ce_sync_r;
    logic           scl_s;
    logic           scl_d;
    logic           sda_s;
    logic           sda_d;
    logic           ce_s;
    logic           wp_s;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_ev;
    logic           stop_ev;
    link_state_t    state_r;
    logic [2:0]     cnt_r;
    logic [DW-1:0]  shift_r;
    logic           phase_r;
    logic           ack_ok_r;
    logic           dir_r;
    logic [2:0]     page_r;
    logic           sda_oe_b_r;
    logic           sda_o_r;
    logic [AW-1:0]  addr_r;
    logic [AW-1:0]  addr_inc;
    logic [DW-1:0]  bit_in;
    logic           last_rise;
    logic           rd_first;
    logic           word_done;
    logic           wr_byte;
    logic           rd_next;
    mem_req_t       req_r;
    logic           req_tgl_r;
    logic [1:0]     ack_sync_r;
    logic           rd_valid;
    logic [DW-1:0]  rd_byte;
    logic           busy_r;
    logic [2:0]     tgl_sync_r;
    logic           go;
    logic           go_d_r;
    logic           ack_tgl_r;
    logic [DW-1:0]  rd_hold_r;
    logic [DW-1:0]  store_rdata;

    ////////////////////////////////////////////////////////////////////////
    // link domain: pin synchronisers, first stage feeds only the second
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
            wp_sync_r  <= 2'h0;
            ce_sync_r  <= 2'h0;
        end else begin
            scl_sync_r[1:0] <= {scl_sync_r[0], scl_i};
            sda_sync_r[1:0] <= {sda_sync_r[0], sda_i};
            wp_sync_r       <= {wp_sync_r[0], wp_i};
            ce_sync_r       <= {ce_sync_r[0], ce};
            if (ce_s) begin
                scl_sync_r[2] <= scl_sync_r[1];
                sda_sync_r[2] <= sda_sync_r[1];
            end
        end
    end

    assign scl_s = scl_sync_r[1];
    assign scl_d = scl_sync_r[2];
    assign sda_s = sda_sync_r[1];
    assign sda_d = sda_sync_r[2];
    assign wp_s  = wp_sync_r[1];
    assign ce_s  = ce_sync_r[1];

    // bus events; the clock is only ever an input here
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_ev = scl_s && scl_d && sda_d && !sda_s;
    assign stop_ev  = scl_s && scl_d && !sda_d && sda_s;

    // msb arrives first, so new bits enter at the bottom
    assign bit_in    = {shift_r[DW-2:0], sda_s};
    assign last_rise = scl_rise && (cnt_r == `FRAM_LAST_BIT);
    assign addr_inc  = addr_r + 11'h001;

    // byte-complete strobes that steer the address latch and requests
    assign rd_first  = (state_r == ST_ADDR) && last_rise
                       && (bit_in[`FRAM_TYPE_MSB:`FRAM_TYPE_LSB] == DEV_TYPE)
                       && bit_in[`FRAM_DIR_BIT];
    assign word_done = (state_r == ST_WORD) && last_rise;
    assign wr_byte   = (state_r == ST_WDATA) && last_rise && !wp_s;
    assign rd_next   = (state_r == ST_RDATA) && last_rise;

    // read data is only trusted once the request has come back
    assign rd_valid = (ack_sync_r[1] == req_tgl_r);
    assign rd_byte  = rd_valid ? rd_hold_r : 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // link domain: protocol engine
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= ST_IDLE;
            cnt_r      <= `FRAM_CNT_RST;
            shift_r    <= `FRAM_BYTE_RST;
            phase_r    <= 1'b0;
            ack_ok_r   <= 1'b0;
            dir_r      <= 1'b0;
            page_r     <= 3'h0;
            sda_oe_b_r <= `FRAM_OE_B_RST;
        end else if (ce_s) begin
            if (start_ev) begin
                // abort anything and expect an address byte
                state_r    <= ST_ADDR;
                cnt_r      <= `FRAM_CNT_RST;
                phase_r    <= 1'b0;
                sda_oe_b_r <= 1'b1;
            end else if (stop_ev) begin
                state_r    <= ST_IDLE;
                phase_r    <= 1'b0;
                sda_oe_b_r <= 1'b1;
            end else begin
                case (state_r)
                    ST_ADDR, ST_WORD, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_r <= bit_in;
                            cnt_r   <= cnt_r + 3'h1;
                            if (cnt_r == `FRAM_LAST_BIT) begin
                                if (state_r == ST_ADDR) begin
                                    if (bit_in[`FRAM_TYPE_MSB:`FRAM_TYPE_LSB] == DEV_TYPE) begin
                                        page_r   <= bit_in[`FRAM_PAGE_MSB:`FRAM_PAGE_LSB];
                                        dir_r    <= bit_in[`FRAM_DIR_BIT];
                                        ack_ok_r <= 1'b1;
                                        state_r  <= ST_AACK;
                                    end else begin
                                        state_r <= ST_IDLE;
                                    end
                                end else if (state_r == ST_WORD) begin
                                    ack_ok_r <= 1'b1;
                                    state_r  <= ST_WACK;
                                end else begin
                                    ack_ok_r <= !wp_s;
                                    state_r  <= ST_DACK;
                                end
                            end
                        end
                    end
                    ST_AACK, ST_WACK, ST_DACK: begin
                        if (scl_fall && !phase_r) begin
                            // ninth clock: pull low only when accepting
                            phase_r    <= 1'b1;
                            sda_oe_b_r <= !ack_ok_r;
                        end else if (scl_fall) begin
                            phase_r    <= 1'b0;
                            sda_oe_b_r <= 1'b1;
                            cnt_r      <= `FRAM_CNT_RST;
                            if (!ack_ok_r) begin
                                state_r <= ST_IDLE;
                            end else if (state_r == ST_AACK && dir_r) begin
                                shift_r    <= {rd_byte[DW-2:0], 1'b0};
                                sda_oe_b_r <= rd_byte[DW-1];
                                state_r    <= ST_RDATA;
                            end else if (state_r == ST_AACK) begin
                                state_r <= ST_WORD;
                            end else begin
                                state_r <= ST_WDATA;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            // outgoing bits change only while scl is low
                            sda_oe_b_r <= shift_r[DW-1];
                            shift_r    <= {shift_r[DW-2:0], 1'b0};
                        end else if (scl_rise) begin
                            cnt_r <= cnt_r + 3'h1;
                            if (cnt_r == `FRAM_LAST_BIT) begin
                                state_r <= ST_RACK;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_fall) begin
                            sda_oe_b_r <= 1'b1;
                        end else if (scl_rise) begin
                            // low means the master wants another byte
                            state_r <= sda_s ? ST_IDLE : ST_RNEXT;
                        end
                    end
                    ST_RNEXT: begin
                        if (scl_fall) begin
                            shift_r    <= {rd_byte[DW-2:0], 1'b0};
                            sda_oe_b_r <= rd_byte[DW-1];
                            cnt_r      <= `FRAM_CNT_RST;
                            state_r    <= ST_RDATA;
                        end
                    end
                    ST_IDLE: begin
                        sda_oe_b_r <= 1'b1;
                    end
                    default: begin
                        state_r    <= ST_IDLE;
                        sda_oe_b_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: address latch with page and auto-increment
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_r <= `FRAM_ADDR_RST;
        end else if (ce_s && !start_ev && !stop_ev) begin
            if (rd_first) begin
                // read keeps the low bits it already holds
                addr_r <= {bit_in[`FRAM_PAGE_MSB:`FRAM_PAGE_LSB], addr_r[`FRAM_ROW_W-1:0]};
            end else if (word_done) begin
                addr_r <= {page_r, bit_in};
            end else if (wr_byte || rd_next) begin
                addr_r <= addr_inc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: request to the store, toggle handshake
    // fields stay stable until the next toggle, so the far side may
    // sample them once it sees the toggle edge
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_r     <= '0;
            req_tgl_r <= 1'b0;
        end else if (ce_s && !start_ev && !stop_ev) begin
            if (rd_first) begin
                req_r.we   <= 1'b0;
                req_r.addr <= {bit_in[`FRAM_PAGE_MSB:`FRAM_PAGE_LSB], addr_r[`FRAM_ROW_W-1:0]};
                req_r.data <= `FRAM_BYTE_RST;
                req_tgl_r  <= !req_tgl_r;
            end else if (wr_byte) begin
                req_r.we   <= 1'b1;
                req_r.addr <= addr_r;
                req_r.data <= bit_in;
                req_tgl_r  <= !req_tgl_r;
            end else if (rd_next) begin
                // prefetch the next byte while the ack clock runs
                req_r.we   <= 1'b0;
                req_r.addr <= addr_inc;
                req_r.data <= `FRAM_BYTE_RST;
                req_tgl_r  <= !req_tgl_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: returning acknowledge and pin registers
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_sync_r <= 2'h0;
            busy_r     <= 1'b0;
            sda_o_r    <= `FRAM_SDA_O_RST;
        end else if (ce_s) begin
            // frozen with the engine so busy and the returned toggle stay in step
            ack_sync_r <= {ack_sync_r[0], ack_tgl_r};
            busy_r     <= (state_r != ST_IDLE) || !rd_valid;
            sda_o_r    <= `FRAM_SDA_O_RST; // open drain: only ever drives low
        end
    end

    assign sda_o     = sda_o_r;
    assign sda_oe_b  = sda_oe_b_r;
    assign xfer_busy = busy_r;

    ////////////////////////////////////////////////////////////////////////
    // system domain: catch the request toggle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tgl_sync_r <= 3'h0;
            go_d_r     <= 1'b0;
        end else if (ce) begin
            tgl_sync_r <= {tgl_sync_r[1:0], req_tgl_r};
            go_d_r     <= go;
        end
    end

    assign go = tgl_sync_r[1] ^ tgl_sync_r[2];

    ////////////////////////////////////////////////////////////////////////
    // system domain: hold read data, then return the toggle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_hold_r <= `FRAM_BYTE_RST;
            ack_tgl_r <= 1'b0;
        end else if (ce && go_d_r) begin
            if (!req_r.we) begin
                rd_hold_r <= store_rdata;
            end
            ack_tgl_r <= tgl_sync_r[2];
        end
    end

    // byte array, one access per handshake
    fram_store #(
        .AW (AW),
        .DW (DW)
    ) u_store (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .wr_en (go && req_r.we),
        .rd_en (go && !req_r.we),
        .addr  (req_r.addr),
        .wdata (req_r.data),
        .rdata (store_rdata)
    );

endmodule : i2c_fram_slave

//--- sim/i2c_fram_props.sv
// protocol checker for the two-wire byte memory slave pins
`timescale 1ns/10ps
module i2c_fram_props
    import fram_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = 4'h5
)(
    // system side
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // link side
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_b,
    input wire logic wp_i,
    input wire logic xfer_busy
);
    logic       scl_q_r;
    logic       sda_q_r;
    logic [3:0] nrise_r;
    logic [7:0] shift_r;
    logic       bad_r;
    wire logic  start_w = scl_i && scl_q_r && sda_q_r && !sda_i;
    wire logic  stop_w  = scl_i && scl_q_r && !sda_q_r && sda_i;
    wire logic  rise_w  = scl_i && !scl_q_r;

    default clocking @(posedge link_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // raw pin history, counts scl rises since the last start or stop
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            nrise_r <= 4'h0;
        end else begin
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
            if (start_w || stop_w) begin
                nrise_r <= 4'h0;
            end else if (rise_w && nrise_r != 4'hf) begin
                nrise_r <= nrise_r + 4'h1; // saturates so long reads stay quiet
            end
        end
    end

    // capture the address byte and judge its type nibble at the eighth rise
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_r <= 8'h00;
            bad_r   <= 1'b0;
        end else begin
            if (rise_w) begin
                shift_r <= {shift_r[6:0], sda_i};
            end
            if (start_w) begin
                bad_r <= 1'b0;
            end else if (rise_w && nrise_r == 4'h7) begin
                bad_r <= (shift_r[6:3] != DEV_TYPE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence start_s;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    sequence stop_s;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence

    a_start_busy: assert property (start_s |-> ##[1:8] xfer_busy)
        else $error("start not taken");
    a_stop_idle: assert property (stop_s |-> ##[1:16] !xfer_busy)
        else $error("stop did not end the transfer");
    a_oe_scl_low: assert property ($changed(sda_oe_b) |-> !scl_i)
        else $error("sda changed while scl high");
    a_sda_low_only: assert property (sda_o == 1'b0)
        else $error("sda output not open drain");
    a_idle_release: assert property (!xfer_busy |-> sda_oe_b)
        else $error("sda driven while idle");
    a_addr_quiet: assert property ((nrise_r < 4'h8) |-> sda_oe_b)
        else $error("sda driven inside the address byte");
    a_bad_type: assert property ((bad_r && nrise_r >= 4'h8) |-> sda_oe_b)
        else $error("foreign type code answered");
    a_drive_hold: assert property ($fell(sda_oe_b) |=> (!sda_oe_b) [*4])
        else $error("driven bit not held");
    a_rst_idle: assert property ($rose(rst_b) |-> sda_oe_b && !xfer_busy)
        else $error("not idle after reset");
endmodule : i2c_fram_props

bind i2c_fram_slave i2c_fram_props #(.DEV_TYPE(DEV_TYPE)) u_props (.clk(clk), .rst_b(rst_b), .ce(ce),
    .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .wp_i(wp_i),
    .xfer_busy(xfer_busy));

//--- sim/i2c_master_bfm.sv
// behavioural bus master that clocks the two-wire link
`timescale 1ns/10ps
module i2c_master_bfm (
    // timing reference
    input wire logic clk,
    // resolved data wire
    input wire logic sda,
    // master drives
    output logic     scl,
    output logic     sda_m
);
    localparam int Q = 13; // quarter bit in clk cycles, keeps both scl phases long enough

    // idle bus: both lines released high
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // data moves only in the scl low phase, sampled mid high
    task automatic bit_io(input logic b, output logic s);
        sda_m = b;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        s = sda;
        tick(Q);
        scl = 1'b0;
        tick(Q);
    endtask : bit_io

    task automatic release_q;
        sda_m = 1'b1;
        tick(Q);
    endtask : release_q

    task automatic start_c;
        sda_m = 1'b1;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sda_m = 1'b0;
        tick(Q);
        scl = 1'b0;
        tick(Q);
    endtask : start_c

    task automatic stop_c;
        sda_m = 1'b0;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sda_m = 1'b1;
        tick(2 * Q);
    endtask : stop_c

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : wbyte

    // the last byte wanted is left without acknowledge
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(!ack, s);
    endtask : rbyte
endmodule : i2c_master_bfm

//--- sim/i2c_fram_slave_access_test.sv
// self-checking bench for the two-wire byte memory slave
`timescale 1ns/10ps
module i2c_fram_slave_access_test;
    import fram_pkg::*;
    localparam logic [3:0] DT = 4'h5; // type code, value is arbitrary
    logic        clk, link_clk, rst_b, wp_i, scl, sda_m, sda, sda_o, sda_oe_b, xfer_busy, ack;
    logic [7:0]  mem_m [0:2047];
    logic [10:0] ptr_m, a;
    logic [7:0]  s4;
    int          n_fail, n_tests, seed;

    // pulled-up wire, either party may pull it low
    assign sda = sda_m & (sda_oe_b | sda_o);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // link clock, phase unrelated to clk
    initial begin
        link_clk = 1'b0;
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    i2c_fram_slave #(.DEV_TYPE(DT)) uut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .link_clk(link_clk), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .wp_i(wp_i), .xfer_busy(xfer_busy));
    i2c_master_bfm mst (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] abyte(input logic [2:0] pg, input logic rd);
        return {DT, pg, rd};
    endfunction : abyte
    function automatic logic [10:0] nxt(input logic [10:0] x);
        return x + 11'h001;
    endfunction : nxt

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // write n random bytes from address x; prot means the data must be refused
    task automatic wr(input logic [10:0] x, input int n, input logic prot);
        logic [7:0] b;
        mst.start_c;
        mst.wbyte(abyte(x[10:8], 1'b0), ack);
        chk("addr ack", 8'(ack), 8'h01);
        mst.wbyte(x[7:0], ack);
        chk("word ack", 8'(ack), 8'h01);
        ptr_m = x;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            mst.wbyte(b, ack);
            chk("data ack", 8'(ack), 8'(!prot));
            if (!prot) begin
                mem_m[ptr_m] = b;
                ptr_m = nxt(ptr_m);
            end
        end
        mst.stop_c;
    endtask : wr

    // current address read of n bytes in page pg
    task automatic rd(input logic [2:0] pg, input int n);
        logic [7:0] v;
        mst.start_c;
        mst.wbyte(abyte(pg, 1'b1), ack);
        chk("raddr ack", 8'(ack), 8'h01);
        ptr_m = {pg, ptr_m[7:0]};
        for (int i = 0; i < n; i++) begin
            mst.rbyte(i < n - 1, v);
            chk("rdata", v, mem_m[ptr_m]);
            ptr_m = nxt(ptr_m);
        end
        mst.stop_c;
        chk("released", 8'(sda_oe_b), 8'h01);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 27;
        n_fail = 0;
        n_tests = 0;
        rst_b = 1'b0;
        wp_i = 1'b0;
        ptr_m = 11'h000;
        repeat (2) @(posedge link_clk);
        @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge link_clk);
        @(posedge clk);
        #1;
        for (int k = 0; k < 4; k++) begin
            a = 11'($random(seed));
            wr(a, 3, 1'b0);
            wr(a, 0, 1'b0);
            rd(a[10:8], 3);
        end
        $display("test random done");
        wr(11'h7fe, 3, 1'b0);
        wr(11'h7ff, 0, 1'b0);
        rd(3'h7, 1);
        rd(3'h0, 1);
        $display("test wrap done");
        // every type nibble, only the own one answers
        for (int t = 0; t < 16; t++) begin
            mst.start_c;
            mst.wbyte({4'(t), 4'h0}, ack);
            chk("type ack", 8'(ack), 8'(4'(t) == DT));
            mst.stop_c;
        end
        $display("test type done");
        wp_i = 1'b1;
        wr(11'h7fe, 1, 1'b1);
        wp_i = 1'b0;
        rd(3'h7, 1);
        $display("test protect done");
        // half a data byte then stop leaves the store untouched
        mst.start_c;
        mst.wbyte(abyte(3'h7, 1'b0), ack);
        mst.wbyte(8'hff, ack);
        ptr_m = 11'h7ff;
        for (int i = 7; i > 3; i--) mst.bit_io(~mem_m[11'h7ff][i], ack);
        mst.stop_c;
        rd(3'h7, 1);
        $display("test abort done");
        // reset while the address is being acknowledged
        mst.start_c;
        s4 = abyte(3'h0, 1'b0);
        for (int i = 7; i >= 0; i--) mst.bit_io(s4[i], ack);
        mst.release_q;
        chk("ack drive", 8'(sda_oe_b), 8'h00);
        rst_b = 1'b0;
        repeat (2) @(posedge link_clk);
        @(posedge clk);
        #1;
        chk("rst oe", 8'(sda_oe_b), 8'h01);
        chk("rst busy", 8'(xfer_busy), 8'h00);
        rst_b = 1'b1;
        ptr_m = 11'h000;
        repeat (4) @(posedge link_clk);
        @(posedge clk);
        #1;
        mst.stop_c;
        rd(3'h0, 1);
        $display("test reset done");
        print_verdict;
    end

    // watchdog, a hang counts as a mismatch
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
endmodule : i2c_fram_slave_access_test
